// file: hw/ussu_top.sv
// Top of the universal serial shift unit: shift register, counter, clock control.
`default_nettype none
module ussu_top
  import ussu_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic serial_clock_pin,
  input wire logic serial_data_in_pin,
  input wire logic [1:0] wire_mode,
  input wire logic [1:0] clk_sel,
  input wire logic data_pin_en,
  input wire logic clk_pin_en,
  input wire logic cpu_data_wr,
  input wire logic [USSU_DATA_W-1:0] cpu_data_wdata,
  input wire logic cpu_cnt_wr,
  input wire logic [USSU_CNT_W-1:0] cpu_cnt_wdata,
  input wire logic ovf_clr,
  input wire logic start_clr,
  input wire logic clk_strobe,
  input wire logic toggle_strobe,
  input wire logic timer0_match,
  input wire logic ovf_irq_en,
  input wire logic start_irq_en,
  output logic [USSU_DATA_W-1:0] cpu_data_rdata,
  output logic [USSU_CNT_W-1:0] cpu_cnt_rdata,
  output logic ovf_flag,
  output logic start_flag,
  output logic ovf_irq,
  output logic start_irq,
  output logic wake_req,
  output logic three_wire_do,
  output logic two_wire_sda_oe,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe
);
  // Reset release chain; everything else uses rst_n_q.
  logic [1:0] rst_sync_q;
  logic rst_n_q;

  // Link-side capture results (serial clock domain).
  logic rise_tog;
  logic fall_tog;
  logic [1:0] rise_bits;
  logic [1:0] fall_bits;

  // Synchronised pins and toggles, plus the last seen toggle values.
  logic [USSU_SY_W-1:0] sy;
  logic rise_seen_q;
  logic fall_seen_q;
  logic din_prev_q;

  // Core state.
  logic [USSU_DATA_W-1:0] shift_q, shift_d;
  logic [USSU_CNT_W-1:0] cnt_q, cnt_d;
  logic latch_q, latch_d;
  logic ovf_q, ovf_d;
  logic start_q, start_d;
  logic clk_out_q;
  ussu_hold_t hold_q, hold_d;

  // Output flops.
  logic ovf_irq_q;
  logic start_irq_q;
  logic wake_q;
  logic do_q;
  logic sda_oe_q;
  logic sck_o_q;
  logic sck_oe_q;

  // Asynchronous assertion, release through two flops.
  // Every mclk flop on rst_n_q then leaves reset on one clean edge, never part-way through a cycle.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_q = rst_sync_q[1];

  // The link logic runs on the pin clock itself and only captures data.
  ussu_link u_link (
    .serial_clock_pin(serial_clock_pin),
    .rst_n(rst_n_q),
    .serial_data_in_pin(serial_data_in_pin),
    .rise_tog(rise_tog),
    .fall_tog(fall_tog),
    .rise_bits(rise_bits),
    .fall_bits(fall_bits)
  );

  // Pins and toggles come into the system domain through two flops each.
  ussu_sync #(
    .WIDTH(USSU_SY_W)
  ) u_sync (
    .clk(mclk),
    .rst_n(rst_n_q),
    .d({serial_clock_pin, serial_data_in_pin, rise_tog, fall_tog}),
    .q(sy)
  );

  // Mode decode.
  // Modes and sources are static levels from the system clock; no sync is needed.
  wire ext_sel = clk_sel[1];
  wire ext_mode1 = (clk_sel == USSU_CS_EXT1);
  wire three_wire = (wire_mode == USSU_WM_THREE);
  wire two_wire = wire_mode[1];
  wire ovf_hold_en = (wire_mode == USSU_WM_TWO_OVF);
  wire sck_s = sy[USSU_SY_SCK];
  wire din_s = sy[USSU_SY_DIN];

  // One event per captured edge, seen as a change of the synchronised toggle.
  wire rise_ev = sy[USSU_SY_RISE] ^ rise_seen_q;
  wire fall_ev = sy[USSU_SY_FALL] ^ fall_seen_q;

  // Internal sources: software strobe or timer compare match.
  wire int_ev = (clk_sel == USSU_CS_SOFT) ? clk_strobe : timer0_match;

  // Sampling edge: rising in mode 0, falling in mode 1.
  wire ext_samp_ev = ext_mode1 ? fall_ev : rise_ev;
  wire samp_ev = ext_sel ? ext_samp_ev : int_ev;

  // The slot read is the one written before the toggle flipped.
  // It is safe to read: the link does not rewrite it until two more edges.
  wire ext_bit = ext_mode1 ? fall_bits[fall_seen_q] : rise_bits[rise_seen_q];
  wire samp_bit = ext_sel ? ext_bit : din_s;

  // Counter step: both edges with an external clock, else one per event.
  // A rise and a fall seen in one cycle add two, so no edge is dropped.
  wire [1:0] ext_step = {1'b0, rise_ev} + {1'b0, fall_ev};
  wire [1:0] cnt_step = ext_sel ? ext_step : {1'b0, int_ev};
  wire [USSU_CNT_W:0] cnt_sum = {1'b0, cnt_q} + {3'h0, cnt_step};

  // Carry out of the counter marks a completed transfer; a write that same
  // cycle replaces the count and suppresses the overflow.
  wire ovf_ev = cnt_sum[USSU_CNT_W] & ~cpu_cnt_wr;

  // Start condition: data falls while the clock line is high.
  wire start_ev = two_wire & sck_s & din_prev_q & ~din_s;

  // Latch is open while the clock sits in its output phase, so the output
  // moves on the edge opposite to sampling. Internal sources keep it open.
  wire latch_open = ~ext_sel | (sck_s == ext_mode1);
  wire hold_low = (hold_q == USSU_HOLD_LOW) | (ovf_hold_en & ovf_q);

  // Next values of the data path and flags.
  always_comb begin
    // A processor write wins over a shift in the same cycle.
    if (cpu_data_wr) begin
      shift_d = cpu_data_wdata;
    end else if (samp_ev) begin
      shift_d = {shift_q[USSU_DATA_W-2:0], samp_bit};
    end else begin
      shift_d = shift_q;
    end
    // The counter takes a processor write before any count.
    if (cpu_cnt_wr) begin
      cnt_d = cpu_cnt_wdata;
    end else begin
      cnt_d = cnt_sum[USSU_CNT_W-1:0];
    end
    latch_d = latch_open ? shift_q[USSU_DATA_W-1] : latch_q;
    // Hardware set wins over a clear in the same cycle.
    ovf_d = ovf_ev | (ovf_q & ~ovf_clr);
    start_d = start_ev | (start_q & ~start_clr);
  end

  // Stretch state: after a start, wait for the clock to go low, then hold it
  // low until software clears the start flag. Never pull during the high phase.
  always_comb begin
    hold_d = hold_q;
    case (hold_q)
      USSU_HOLD_IDLE: begin
        if (start_ev) begin
          hold_d = USSU_HOLD_ARMED;
        end
      end
      USSU_HOLD_ARMED: begin
        if (!start_d) begin
          hold_d = USSU_HOLD_IDLE;
        end else if (!sck_s) begin
          hold_d = USSU_HOLD_LOW;
        end
      end
      USSU_HOLD_LOW: begin
        if (!start_d) begin
          hold_d = USSU_HOLD_IDLE;
        end
      end
      default: begin
        hold_d = USSU_HOLD_IDLE;
      end
    endcase
    if (!two_wire) begin
      hold_d = USSU_HOLD_IDLE;
    end
  end

  // Pin drive. Three-wire pushes the clock; two-wire only ever pulls low.
  // The enables follow the registered stretch state and flags, so a release
  // reaches the pins one cycle after the flag clears.
  wire sck_oe_3w = clk_pin_en;
  wire sck_oe_2w = (clk_pin_en & ~clk_out_q) | hold_low;
  wire sck_oe_d = three_wire ? sck_oe_3w : (two_wire & sck_oe_2w);
  wire sck_o_d = three_wire & clk_out_q;
  wire do_d = three_wire & latch_d;
  wire sda_oe_d = two_wire & data_pin_en & ~latch_d;

  // Edge history for event detection.
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rise_seen_q <= 1'b0;
      fall_seen_q <= 1'b0;
      din_prev_q <= 1'b1;
    end else begin
      rise_seen_q <= sy[USSU_SY_RISE];
      fall_seen_q <= sy[USSU_SY_FALL];
      din_prev_q <= din_s;
    end
  end

  // Data path, counter, flags and stretch state.
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      shift_q <= USSU_DATA_RST;
      cnt_q <= USSU_CNT_RST;
      latch_q <= 1'b0;
      ovf_q <= 1'b0;
      start_q <= 1'b0;
      hold_q <= USSU_HOLD_IDLE;
    end else begin
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      latch_q <= latch_d;
      ovf_q <= ovf_d;
      start_q <= start_d;
      hold_q <= hold_d;
    end
  end

  // Software-driven clock level; a master toggles it by strobe.
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      clk_out_q <= 1'b0;
    end else if (toggle_strobe) begin
      clk_out_q <= ~clk_out_q;
    end
  end

  // Registered outputs. The wake request needs mclk running; a design that
  // gates mclk in deep sleep must take wake from the start flag path.
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ovf_irq_q <= 1'b0;
      start_irq_q <= 1'b0;
      wake_q <= 1'b0;
      do_q <= 1'b0;
      sda_oe_q <= 1'b0;
      sck_o_q <= 1'b0;
      sck_oe_q <= 1'b0;
    end else begin
      ovf_irq_q <= ovf_d & ovf_irq_en;
      start_irq_q <= start_d & start_irq_en;
      wake_q <= start_d & two_wire;
      do_q <= do_d;
      sda_oe_q <= sda_oe_d;
      sck_o_q <= sck_o_d;
      sck_oe_q <= sck_oe_d;
    end
  end

  // Ports straight from flops.
  assign cpu_data_rdata = shift_q;
  assign cpu_cnt_rdata = cnt_q;
  assign ovf_flag = ovf_q;
  assign start_flag = start_q;
  assign ovf_irq = ovf_irq_q;
  assign start_irq = start_irq_q;
  assign wake_req = wake_q;
  assign three_wire_do = do_q;
  assign two_wire_sda_oe = sda_oe_q;
  assign serial_clock_pin_o = sck_o_q;
  assign serial_clock_pin_oe = sck_oe_q;
endmodule : ussu_top
`default_nettype wire

// file: hw/ussu_pkg.sv
// Shared constants and types for the universal serial shift unit.
`default_nettype none
package ussu_pkg;
  // Data path widths.
  localparam int unsigned USSU_DATA_W = 8;
  localparam int unsigned USSU_CNT_W = 4;
  // Values after reset.
  localparam logic [7:0] USSU_DATA_RST = 8'h00;
  localparam logic [3:0] USSU_CNT_RST = 4'h0;
  // Wire mode codes: off, three-wire, two-wire, two-wire with overflow hold.
  localparam logic [1:0] USSU_WM_OFF = 2'h0;
  localparam logic [1:0] USSU_WM_THREE = 2'h1;
  localparam logic [1:0] USSU_WM_TWO = 2'h2;
  localparam logic [1:0] USSU_WM_TWO_OVF = 2'h3;
  // Clock source codes: software strobe, timer compare, external mode 0 and 1.
  localparam logic [1:0] USSU_CS_SOFT = 2'h0;
  localparam logic [1:0] USSU_CS_TIMER = 2'h1;
  localparam logic [1:0] USSU_CS_EXT0 = 2'h2;
  localparam logic [1:0] USSU_CS_EXT1 = 2'h3;
  // Bit positions inside the synchronised pin and toggle vector.
  localparam int unsigned USSU_SY_FALL = 0;
  localparam int unsigned USSU_SY_RISE = 1;
  localparam int unsigned USSU_SY_DIN = 2;
  localparam int unsigned USSU_SY_SCK = 3;
  localparam int unsigned USSU_SY_W = 4;
  // Clock stretch states after a start condition.
  typedef enum logic [2:0] {
    USSU_HOLD_IDLE = 3'b001,
    USSU_HOLD_ARMED = 3'b010,
    USSU_HOLD_LOW = 3'b100
  } ussu_hold_t;
endpackage : ussu_pkg
`default_nettype wire

// file: hw/ussu_sync.sv
// Two flip-flop synchroniser for a vector of independent levels.
`default_nettype none
module ussu_sync #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // First stage; only the second stage reads it.
  logic [WIDTH-1:0] meta_q;

  // Each bit is an independent level, so no coherence between bits is promised.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : ussu_sync
`default_nettype wire

// file: hw/ussu_link.sv
// Link-side capture of the data pin on both edges of the serial clock pin.
`default_nettype none
module ussu_link (
  input wire logic serial_clock_pin,
  input wire logic rst_n,
  input wire logic serial_data_in_pin,
  output logic rise_tog,
  output logic fall_tog,
  output logic [1:0] rise_bits,
  output logic [1:0] fall_bits
);
  // Rising edge: store the pin in the slot named by the toggle, then flip it.
  // Two slots keep each captured bit stable for two clock periods, long
  // enough for the system side to see the toggle and read the slot.
  always_ff @(posedge serial_clock_pin or negedge rst_n) begin
    if (!rst_n) begin
      rise_tog <= 1'b0;
      rise_bits <= 2'h0;
    end else begin
      rise_bits[rise_tog] <= serial_data_in_pin;
      rise_tog <= ~rise_tog;
    end
  end

  // Falling edge: same scheme for the opposite clock phase.
  always_ff @(negedge serial_clock_pin or negedge rst_n) begin
    if (!rst_n) begin
      fall_tog <= 1'b0;
      fall_bits <= 2'h0;
    end else begin
      fall_bits[fall_tog] <= serial_data_in_pin;
      fall_tog <= ~fall_tog;
    end
  end
endmodule : ussu_link
`default_nettype wire

// file: bench/ussu_top_chk.sv
// Port-level assertions for the universal serial shift unit.
`default_nettype none
module ussu_top_chk
  import ussu_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [1:0] wire_mode,
  input wire logic [1:0] clk_sel,
  input wire logic cpu_data_wr,
  input wire logic [USSU_DATA_W-1:0] cpu_data_wdata,
  input wire logic cpu_cnt_wr,
  input wire logic [USSU_CNT_W-1:0] cpu_cnt_wdata,
  input wire logic clk_strobe,
  input wire logic ovf_clr,
  input wire logic ovf_irq_en,
  input wire logic start_irq_en,
  input wire logic [USSU_DATA_W-1:0] cpu_data_rdata,
  input wire logic [USSU_CNT_W-1:0] cpu_cnt_rdata,
  input wire logic ovf_flag,
  input wire logic start_flag,
  input wire logic ovf_irq,
  input wire logic start_irq,
  input wire logic wake_req,
  input wire logic three_wire_do,
  input wire logic serial_clock_pin_oe
);
  // All checks live in the system clock domain.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  a_data_write: assert property (
    cpu_data_wr |=> cpu_data_rdata == $past(cpu_data_wdata)) else $error("data write lost");
  a_cnt_write: assert property (
    cpu_cnt_wr |=> cpu_cnt_rdata == $past(cpu_cnt_wdata)) else $error("count write lost");
  a_soft_step: assert property (
    clk_sel == USSU_CS_SOFT && clk_strobe && !cpu_data_wr && !cpu_cnt_wr
    |=> cpu_cnt_rdata == $past(cpu_cnt_rdata) + 4'h1
    && cpu_data_rdata[7:1] == $past(cpu_data_rdata[6:0])) else $error("soft step wrong");
  a_ovf_wrap: assert property (
    $past(cpu_cnt_rdata) == 4'hf && cpu_cnt_rdata == 4'h0 && !$past(cpu_cnt_wr)
    |-> ovf_flag) else $error("wrap without overflow");
  a_ovf_sticky: assert property (
    ovf_flag && !ovf_clr |=> ovf_flag) else $error("overflow flag dropped");
  a_ovf_irq_gate: assert property (
    ovf_irq == (ovf_flag && $past(ovf_irq_en))) else $error("overflow irq wrong");
  a_start_irq_gate: assert property (
    start_irq == (start_flag && $past(start_irq_en))) else $error("start irq wrong");
  a_wake_start: assert property (
    wake_req == (start_flag && $past(wire_mode[1]))) else $error("wake wrong");
  a_do_mode: assert property (
    $past(wire_mode) != USSU_WM_THREE |-> !three_wire_do) else $error("data out in wrong mode");
  a_ovf_hold: assert property (
    ovf_flag && wire_mode == USSU_WM_TWO_OVF |=> serial_clock_pin_oe)
    else $error("clock not held");
endmodule : ussu_top_chk
bind ussu_top ussu_top_chk chk_u (.*);
`default_nettype wire

// file: bench/ussu_peer.sv
// Behavioural serial peer: drives the clock and data pins of the unit.
`default_nettype none
module ussu_peer (
  output logic sck,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock stands low outside frames.
  initial begin
    sck = 1'b0;
    sda = 1'b0;
  end
  // One byte MSB first, 64 ns clock; data moves mid low phase so both modes sample it.
  task automatic send_byte(input logic [7:0] b);
    #7;
    for (int i = 7; i >= 0; i--) begin
      #16 sda = b[i];
      #16 sck = 1'b1;
      #32 sck = 1'b0;
    end
    // Released data shows the inverse so a stale value is never trusted.
    #16 sda = ~b[0];
  endtask : send_byte
  // Data falls while clock is high, then clock goes low.
  task automatic start_cond();
    sda = 1'b1;
    #32 sck = 1'b1;
    #200 sda = 1'b0;
    #200 sck = 1'b0;
  endtask : start_cond
endmodule : ussu_peer
`default_nettype wire

// file: bench/ussu_top_test.sv
// Self-checking bench for the universal serial shift unit.
`default_nettype none
module ussu_top_test
  import ussu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic serial_clock_pin, serial_data_in_pin;
  logic [1:0] wire_mode = USSU_WM_OFF, clk_sel = USSU_CS_SOFT;
  logic data_pin_en = 1'b0, clk_pin_en = 1'b0, toggle_strobe = 1'b0;
  logic cpu_data_wr = 1'b0, cpu_cnt_wr = 1'b0, ovf_clr = 1'b0, start_clr = 1'b0;
  logic clk_strobe = 1'b0, timer0_match = 1'b0, ovf_irq_en = 1'b0, start_irq_en = 1'b0;
  logic [USSU_DATA_W-1:0] cpu_data_wdata = 8'h00, cpu_data_rdata;
  logic [USSU_CNT_W-1:0] cpu_cnt_wdata = 4'h0, cpu_cnt_rdata;
  logic ovf_flag, start_flag, ovf_irq, start_irq, wake_req, three_wire_do;
  logic two_wire_sda_oe, serial_clock_pin_o, serial_clock_pin_oe;
  int fails = 0;
  int samples_checked = 0;
  // System clock, 40 ns.
  always #20 mclk = ~mclk;
  ussu_top dut_u (.*);
  ussu_peer peer_u (.sck(serial_clock_pin), .sda(serial_data_in_pin));
  task automatic conclude();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  // One-cycle strobe launched and dropped at falling edges.
  task automatic pulse(ref logic s);
    @(negedge mclk) s = 1'b1;
    @(negedge mclk) s = 1'b0;
  endtask : pulse
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle
  // Preload data and count, then clear any old overflow.
  task automatic load(input logic [7:0] d, input logic [3:0] c);
    cpu_data_wdata = d;
    cpu_cnt_wdata = c;
    pulse(cpu_data_wr);
    pulse(cpu_cnt_wr);
    pulse(ovf_clr);
  endtask : load
  task automatic t_reg();
    load(8'ha5, 4'h9);
    check("data", cpu_data_rdata, 8'ha5);
    check("count", cpu_cnt_rdata, 4'h9);
    $display("t_reg done");
  endtask : t_reg
  task automatic t_soft();
    peer_u.sda = 1'b1;
    ovf_irq_en = 1'b1;
    load(8'h3c, 4'h0);
    for (int i = 1; i <= 16; i++) begin
      pulse(clk_strobe);
      if (i == 4) check("shift4", cpu_data_rdata, 8'hcf);
      if (i == 8) check("shift8", cpu_data_rdata, 8'hff);
      if (i == 15) check("ovf15", ovf_flag, 1'b0);
    end
    check("wrap", cpu_cnt_rdata, 4'h0);
    check("ovf", ovf_flag, 1'b1);
    check("ovf irq", ovf_irq, 1'b1);
    pulse(ovf_clr);
    check("ovf clr", ovf_flag, 1'b0);
    $display("t_soft done");
  endtask : t_soft
  // The strobe must not count while the timer is the source.
  task automatic t_timer();
    clk_sel = USSU_CS_TIMER;
    load(8'h00, 4'h0);
    repeat (3) pulse(timer0_match);
    pulse(clk_strobe);
    check("timer count", cpu_cnt_rdata, 4'h3);
    check("timer data", cpu_data_rdata, 8'h07);
    $display("t_timer done");
  endtask : t_timer
  task automatic t_ext(input logic [1:0] sel, input logic [7:0] b);
    wire_mode = USSU_WM_THREE;
    clk_sel = sel;
    load(8'h5a, 4'h0);
    idle(2);
    if (sel == USSU_CS_EXT0) check("do idle", three_wire_do, 1'b0);
    peer_u.send_byte(b);
    idle(6);
    check("ext data", cpu_data_rdata, b);
    check("ext count", cpu_cnt_rdata, 4'h0);
    check("ext ovf", ovf_flag, 1'b1);
    if (sel == USSU_CS_EXT0) check("do last", three_wire_do, b[7]);
    $display("t_ext done");
  endtask : t_ext
  task automatic t_start();
    wire_mode = USSU_WM_TWO;
    clk_sel = USSU_CS_SOFT;
    start_irq_en = 1'b1;
    peer_u.start_cond();
    idle(6);
    check("start", start_flag, 1'b1);
    check("start irq", start_irq, 1'b1);
    check("wake", wake_req, 1'b1);
    check("scl hold", serial_clock_pin_oe, 1'b1);
    pulse(start_clr);
    check("start clr", start_flag, 1'b0);
    // The clock pin follows the registered stretch state one cycle later.
    idle(1);
    check("scl free", serial_clock_pin_oe, 1'b0);
    $display("t_start done");
  endtask : t_start
  task automatic t_hold();
    wire_mode = USSU_WM_TWO_OVF;
    ovf_irq_en = 1'b0;
    load(8'h00, 4'hf);
    pulse(clk_strobe);
    check("hold ovf", ovf_flag, 1'b1);
    check("irq masked", ovf_irq, 1'b0);
    idle(1);
    check("hold scl", serial_clock_pin_oe, 1'b1);
    pulse(ovf_clr);
    idle(1);
    check("hold free", serial_clock_pin_oe, 1'b0);
    $display("t_hold done");
  endtask : t_hold
  // Master drive of the clock pin and the open-drain pull of the data pin.
  task automatic t_pins();
    wire_mode = USSU_WM_THREE;
    clk_sel = USSU_CS_SOFT;
    clk_pin_en = 1'b1;
    pulse(toggle_strobe);
    idle(1);
    check("sck out", serial_clock_pin_o, 1'b1);
    check("sck oe 3w", serial_clock_pin_oe, 1'b1);
    wire_mode = USSU_WM_TWO;
    data_pin_en = 1'b1;
    load(8'h00, 4'h0);
    check("sck rel 2w", serial_clock_pin_oe, 1'b0);
    check("sck lvl 2w", serial_clock_pin_o, 1'b0);
    check("sda pull", two_wire_sda_oe, 1'b1);
    load(8'h80, 4'h0);
    check("sda free", two_wire_sda_oe, 1'b0);
    pulse(toggle_strobe);
    idle(1);
    check("sck pull 2w", serial_clock_pin_oe, 1'b1);
    $display("t_pins done");
  endtask : t_pins
  initial begin
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    idle(3);
    t_reg();
    t_soft();
    t_timer();
    t_ext(USSU_CS_EXT0, 8'h96);
    t_ext(USSU_CS_EXT1, 8'h69);
    t_start();
    t_hold();
    t_pins();
    conclude();
  end
  // The tests take under 7 us; a hang ends here at 100 us.
  initial begin
    #100us;
    fails++;
    conclude();
  end
endmodule : ussu_top_test
`default_nettype wire
